// [hw/bmt_defines.svh]
// Constants for the burst and multiple-cycle bus transfer block
`ifndef BMT_DEFINES_SVH
`define BMT_DEFINES_SVH
`define BMT_AW            32
`define BMT_DW            32
`define BMT_LINE_BYTES    5'h10
`define BMT_WORD_BYTES    5'h04
`define BMT_HALF_BYTES    5'h02
`define BMT_ONE_BYTE      5'h01
`define BMT_FIRST_DATA_CLKS 2'h2
`define BMT_MEM_WAIT      2'h1
`define BMT_BE_ALL_N      4'h0
`define BMT_BE_NONE_N     4'hF
`define BMT_BE_LANE0      4'h1
`define BMT_BE_LOW_HALF_N 4'hC
`define BMT_BE_HIGH_HALF_N 4'h3
`endif

// [hw/bmt_pkg.sv]
// Types shared by both ends of the burst bus link
package bmt_pkg;
  typedef enum logic [1:0] {
    BMT_CYC_MEM_READ,
    BMT_CYC_MEM_WRITE,
    BMT_CYC_SPECIAL
  } bmt_kind_e;
  typedef enum logic [1:0] {
    BMT_SZ_32,
    BMT_SZ_16,
    BMT_SZ_8
  } bmt_size_e;
endpackage

// [hw/bmt_bus_if.sv]
// Local bus between the processor end and the memory end
`timescale 1ns/1ns
interface bmt_bus_if;
  logic [31:4] upper_address_bits;
  logic [3:2]  addr_word;
  logic [3:0]  byte_enables_n;
  logic        address_strobe_n;
  logic        last_transfer_n;
  logic        mem_io;
  logic        data_code;
  logic        write_read;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ready_n;
  logic        burst_ready_n;
  logic        cache_enable_in_n;
  logic        bus_size_byte_n;
  logic        bus_size_half_n;
  modport proc (
    output upper_address_bits, addr_word, byte_enables_n, address_strobe_n, last_transfer_n,
    output mem_io, data_code, write_read, wdata,
    input  rdata, ready_n, burst_ready_n, cache_enable_in_n, bus_size_byte_n, bus_size_half_n
  );
  modport mem (
    input  upper_address_bits, addr_word, byte_enables_n, address_strobe_n, last_transfer_n,
    input  mem_io, data_code, write_read, wdata,
    output rdata, ready_n, burst_ready_n, cache_enable_in_n, bus_size_byte_n, bus_size_half_n
  );
endinterface

// [hw/bmt_order.sv]
// Burst order step and item count calculator
`timescale 1ns/1ns
`include "bmt_defines.svh"
module bmt_order
  import bmt_pkg::*;
(
  input  wire logic [1:0] first_word,
  input  wire logic [1:0] step,
  input  wire logic [4:0] nbytes,
  input  wire logic       cacheable,
  input  wire logic       burst_ok,
  input  wire logic       bs8_n,
  input  wire logic       bus_size_half_n_n,
  output logic      [1:0] word_now,
  output logic      [4:0] total_items
);
  logic [4:0] bytes_eff;
  logic [4:0] per_item;
  always_comb begin
    // Burst order: xor of start word with step index
    word_now  = first_word ^ step;
    bytes_eff = (cacheable && burst_ok) ? `BMT_LINE_BYTES : nbytes;
    if (!bs8_n) begin
      per_item = `BMT_ONE_BYTE;
    end else if (!bus_size_half_n_n) begin
      per_item = `BMT_HALF_BYTES;
    end else begin
      per_item = `BMT_WORD_BYTES;
    end
    // Sizes are powers of two so shifts give exact counts
    if (per_item == `BMT_ONE_BYTE) begin
      total_items = bytes_eff;
    end else if (per_item == `BMT_HALF_BYTES) begin
      total_items = (bytes_eff + 5'h01) >> 1;
    end else begin
      total_items = (bytes_eff + 5'h03) >> 2;
    end
  end
endmodule

// [hw/bmt_proc_end.sv]
// Processor end: sequences multiple-cycle and burst transfers
`timescale 1ns/1ns
`include "bmt_defines.svh"
module bmt_proc_end
  import bmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  bmt_bus_if.proc          bus,
  input  wire logic        req_valid,
  input  wire bmt_kind_e   req_kind,
  input  wire logic [31:0] req_addr,
  input  wire logic [4:0]  req_bytes,
  input  wire logic        req_code,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data,
  output logic             rsp_last
);
  typedef enum logic [1:0] {BMT_IDLE, BMT_T1, BMT_T2} bmt_st_e;
  typedef struct packed {
    bmt_st_e     st;
    logic [27:0] upper;
    logic [1:0]  first_word;
    logic [1:0]  step;
    logic [1:0]  sub;
    logic [4:0]  items_left;
    logic        sized;
    logic        bursting;
    bmt_kind_e   kind;
    logic        code;
    logic [4:0]  nbytes;
    logic [31:0] wdata;
    logic        ads_n;
    logic        last_n;
    logic [3:0]  be_n;
    logic [1:0]  aw;
    logic        req_ready;
    logic        rsp_valid;
    logic [31:0] rsp_data;
    logic        rsp_last;
  } bmt_proc_s;
  bmt_proc_s cur_ff, nxt_cur;
  logic [1:0] word_now;
  logic [4:0] total_items;
  logic       rdy_s;
  logic       burst_ready_n_s;
  logic       ken_s;
  logic       bs8_s;
  logic       bus_size_half_n_s;
  logic       can_burst;
  ////////////////////////////////////////////////////////////////////////////
  // Inputs are same-clock logic from the memory end, so no synchroniser
  assign rdy_s     = !bus.ready_n;
  assign burst_ready_n_s    = !bus.burst_ready_n && bus.ready_n;
  assign ken_s     = !bus.cache_enable_in_n;
  assign bs8_s     = bus.bus_size_byte_n;
  assign bus_size_half_n_s    = bus.bus_size_half_n;
  // Writes burst only on a narrow bus; special cycles never burst
  assign can_burst = (cur_ff.kind == BMT_CYC_MEM_READ) ||
                     ((cur_ff.kind == BMT_CYC_MEM_WRITE) && (!bs8_s || !bus_size_half_n_s));
  bmt_order u_order (
    .first_word  (cur_ff.first_word),
    .step        (cur_ff.step),
    .nbytes      (cur_ff.nbytes),
    .cacheable   (ken_s && cur_ff.kind == BMT_CYC_MEM_READ),
    .burst_ok    (1'b1),
    .bs8_n       (bs8_s),
    .bus_size_half_n_n      (bus_size_half_n_s),
    .word_now    (word_now),
    .total_items (total_items)
  );
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_cur           = cur_ff;
    nxt_cur.ads_n     = 1'b1;
    nxt_cur.rsp_valid = 1'b0;
    nxt_cur.rsp_last  = 1'b0;
    unique case (cur_ff.st)
      BMT_IDLE: begin
        nxt_cur.req_ready = 1'b1;
        if (req_valid && cur_ff.req_ready) begin
          nxt_cur.req_ready  = 1'b0;
          nxt_cur.upper      = req_addr[31:4];
          nxt_cur.first_word = req_addr[3:2];
          nxt_cur.aw         = req_addr[3:2];
          nxt_cur.step       = 2'h0;
          nxt_cur.sub        = 2'h0;
          nxt_cur.kind       = req_kind;
          nxt_cur.code       = req_code;
          nxt_cur.nbytes     = req_bytes;
          nxt_cur.wdata      = req_wdata;
          nxt_cur.sized      = 1'b0;
          nxt_cur.bursting   = 1'b0;
          nxt_cur.ads_n      = 1'b0;
          nxt_cur.last_n     = 1'b1;
          nxt_cur.be_n       = `BMT_BE_ALL_N;
          nxt_cur.st         = BMT_T1;
        end
      end
      BMT_T1: begin
        // Last-transfer is only meaningful from the second clock
        nxt_cur.st = BMT_T2;
        if (!cur_ff.sized) begin
          nxt_cur.items_left = total_items;
          nxt_cur.last_n     = (total_items > 5'h01) ? 1'b1 : 1'b0;
        end
      end
      BMT_T2: begin
        if (!cur_ff.sized) begin
          nxt_cur.items_left = total_items;
          nxt_cur.last_n     = (total_items > 5'h01) ? 1'b1 : 1'b0;
        end
        // Burst-ready on an unburstable cycle ends the item as ready does
        if (rdy_s || burst_ready_n_s) begin
          nxt_cur.sized     = 1'b1;
          nxt_cur.rsp_valid = 1'b1;
          nxt_cur.rsp_data  = bus.rdata;
          nxt_cur.items_left = (cur_ff.sized ? cur_ff.items_left : total_items) - 5'h01;
          if (cur_ff.sized ? (cur_ff.items_left <= 5'h01) : (total_items <= 5'h01)) begin
            nxt_cur.rsp_last  = 1'b1;
            nxt_cur.last_n    = 1'b1;
            nxt_cur.st        = BMT_IDLE;
          end else begin
            // Narrow items finish the current word before moving on
            if ((!bs8_s && cur_ff.sub != 2'h3) || (bs8_s && !bus_size_half_n_s && cur_ff.sub == 2'h0)) begin
              nxt_cur.sub = cur_ff.sub + 2'h1;
            end else begin
              nxt_cur.sub  = 2'h0;
              nxt_cur.step = cur_ff.step + 2'h1;
            end
            nxt_cur.last_n = ((cur_ff.sized ? cur_ff.items_left : total_items) > 5'h02) ? 1'b1 : 1'b0;
            nxt_cur.bursting = burst_ready_n_s && can_burst;
            if (burst_ready_n_s && can_burst) begin
              nxt_cur.st = BMT_T2;
            end else begin
              nxt_cur.ads_n = 1'b0;
              nxt_cur.st    = BMT_T1;
            end
          end
        end
      end
      default: nxt_cur.st = BMT_IDLE;
    endcase
    // Only word select and byte enables move inside one line
    // Start word of a new request is used at once so the strobe clock is right
    nxt_cur.aw = nxt_cur.first_word ^ nxt_cur.step;
    if (!bs8_s) begin
      nxt_cur.be_n = ~(`BMT_BE_LANE0 << nxt_cur.sub);
    end else if (!bus_size_half_n_s) begin
      nxt_cur.be_n = nxt_cur.sub[0] ? `BMT_BE_HIGH_HALF_N : `BMT_BE_LOW_HALF_N;
    end else begin
      nxt_cur.be_n = `BMT_BE_ALL_N;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.st <= BMT_IDLE;
      cur_ff.ads_n <= 1'b1;
      cur_ff.last_n <= 1'b1;
      cur_ff.be_n <= `BMT_BE_NONE_N;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign bus.upper_address_bits = cur_ff.upper;
  assign bus.addr_word          = cur_ff.aw;
  assign bus.byte_enables_n     = cur_ff.be_n;
  assign bus.address_strobe_n   = cur_ff.ads_n;
  assign bus.last_transfer_n    = cur_ff.last_n;
  assign bus.mem_io             = (cur_ff.kind != BMT_CYC_SPECIAL);
  assign bus.data_code          = !cur_ff.code;
  assign bus.write_read         = (cur_ff.kind == BMT_CYC_MEM_WRITE);
  assign bus.wdata              = cur_ff.wdata;
  assign req_ready              = cur_ff.req_ready;
  assign rsp_valid              = cur_ff.rsp_valid;
  assign rsp_data               = cur_ff.rsp_data;
  assign rsp_last               = cur_ff.rsp_last;
  logic unused_word;
  assign unused_word = ^word_now;
endmodule

// [hw/bmt_mem_end.sv]
// Memory end: answers strobes with ready or burst-ready
`timescale 1ns/1ns
`include "bmt_defines.svh"
module bmt_mem_end
  import bmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  bmt_bus_if.mem           bus,
  input  wire logic        cfg_burst_en,
  input  wire logic        cfg_cacheable,
  input  wire bmt_size_e   cfg_size,
  input  wire logic [31:0] mem_rdata,
  output logic [31:0]      mem_addr,
  output logic             mem_wr
);
  typedef enum logic [1:0] {BMT_M_IDLE, BMT_M_WAIT, BMT_M_DATA} bmt_mst_e;
  typedef struct packed {
    bmt_mst_e    st;
    logic        rdy_n;
    logic        burst_ready_n_n;
    logic        ken_n;
    logic        bs8_n;
    logic        bus_size_half_n_n;
    logic        wr;
  } bmt_mem_s;
  bmt_mem_s cur_ff, nxt_cur;
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.rdy_n  = 1'b1;
    nxt_cur.burst_ready_n_n = 1'b1;
    nxt_cur.wr     = 1'b0;
    // Size and cache inputs settle a clock ahead of any ready
    nxt_cur.ken_n  = !cfg_cacheable;
    nxt_cur.bs8_n  = (cfg_size != BMT_SZ_8);
    nxt_cur.bus_size_half_n_n = (cfg_size != BMT_SZ_16);
    unique case (cur_ff.st)
      BMT_M_IDLE: begin
        if (!bus.address_strobe_n) begin
          nxt_cur.st = BMT_M_DATA;
        end
      end
      BMT_M_WAIT: nxt_cur.st = BMT_M_DATA;
      BMT_M_DATA: begin
        if (!cur_ff.rdy_n || !cur_ff.burst_ready_n_n) begin
          // Last-transfer is read only when a ready is answered
          if (!bus.last_transfer_n) begin
            nxt_cur.st = BMT_M_IDLE;
          end else if (!cur_ff.burst_ready_n_n) begin
            nxt_cur.st = BMT_M_DATA;
          end else begin
            nxt_cur.st = BMT_M_IDLE;
          end
        end
        // Ready type may change between items; ready mid-burst ends the burst
        if (nxt_cur.st == BMT_M_DATA) begin
          nxt_cur.wr = bus.write_read;
          if (cfg_burst_en) begin
            nxt_cur.burst_ready_n_n = 1'b0;
          end else begin
            nxt_cur.rdy_n = 1'b0;
          end
        end
      end
      default: nxt_cur.st = BMT_M_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.st <= BMT_M_IDLE;
      cur_ff.rdy_n <= 1'b1;
      cur_ff.burst_ready_n_n <= 1'b1;
      cur_ff.ken_n <= 1'b1;
      cur_ff.bs8_n <= 1'b1;
      cur_ff.bus_size_half_n_n <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  assign bus.ready_n           = cur_ff.rdy_n;
  assign bus.burst_ready_n     = cur_ff.burst_ready_n_n;
  assign bus.cache_enable_in_n = cur_ff.ken_n;
  assign bus.bus_size_byte_n   = cur_ff.bs8_n;
  assign bus.bus_size_half_n   = cur_ff.bus_size_half_n_n;
  // Data follows the address in the same clock so one-clock burst items keep pace
  assign bus.rdata             = mem_rdata;
  assign mem_addr              = {bus.upper_address_bits, bus.addr_word, 2'h0};
  assign mem_wr                = cur_ff.wr;
endmodule

// [verification/bmt_bus_chk.sv]
// Protocol checker watching the bus between the two ends
`timescale 1ns/1ns
module bmt_bus_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:4] upper_address_bits,
  input wire logic        address_strobe_n,
  input wire logic        last_transfer_n,
  input wire logic        mem_io,
  input wire logic        data_code,
  input wire logic        write_read,
  input wire logic        ready_n,
  input wire logic        burst_ready_n,
  input wire logic        cache_enable_in_n,
  input wire logic        bus_size_byte_n,
  input wire logic        bus_size_half_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Transfer in flight: strobe opens it, terminating ready on last closes it
  logic busy_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (!address_strobe_n) begin
      busy_ff <= 1'b1;
    end else if (!(ready_n && burst_ready_n) && !last_transfer_n) begin
      busy_ff <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  strobe_one_clk_a: assert property (!address_strobe_n |=> address_strobe_n)
    else $error("address strobe held longer than one clock");
  no_early_ready_a: assert property (!address_strobe_n |-> ready_n && burst_ready_n)
    else $error("ready seen in the strobe clock");
  ready_excl_a: assert property (!burst_ready_n |-> ready_n)
    else $error("both readies low together");
  ready_in_cycle_a: assert property (!(ready_n && burst_ready_n) |-> busy_ff)
    else $error("ready outside a bus cycle");
  burst_stable_a: assert property (!burst_ready_n && last_transfer_n |=>
    $stable(upper_address_bits) && $stable(mem_io) && $stable(data_code) && $stable(write_read))
    else $error("upper address or cycle kind moved in a burst");
  burst_no_strobe_a: assert property (!burst_ready_n && last_transfer_n |=> address_strobe_n)
    else $error("new strobe inside a burst");
  ready_restrobe_a: assert property (!ready_n && last_transfer_n |-> ##[1:4] !address_strobe_n)
    else $error("no fresh strobe after ready on a non-final item");
  sizes_early_a: assert property (!(ready_n && burst_ready_n) |->
    $stable(cache_enable_in_n) && $stable(bus_size_byte_n) && $stable(bus_size_half_n))
    else $error("cache or size input changed in the ready clock");
  last_ends_a: assert property (!last_transfer_n && !(ready_n && burst_ready_n) |=>
    ready_n && burst_ready_n)
    else $error("ready after the final item");
endmodule

// [verification/test_burst_multicycle_bus_transfer.sv]
// Testbench running both ends back to back through read and write transfers
`timescale 1ns/1ns
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module test_burst_multicycle_bus_transfer;
  import bmt_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  bmt_kind_e   req_kind = BMT_CYC_MEM_READ;
  logic [31:0] req_addr = 32'h0;
  logic [4:0]  req_bytes = 5'h04;
  logic [31:0] req_wdata = 32'hC3A55A3C;
  logic        req_ready, rsp_valid, rsp_last, mem_wr;
  logic [31:0] rsp_data, mem_addr, mem_rdata;
  logic        cfg_burst_en = 1'b0;
  logic        cfg_cacheable = 1'b0;
  bmt_size_e   cfg_size = BMT_SZ_32;
  int          failures = 0;
  int          tests_run = 0;
  int          n_strobe = 0, n_last = 0, n_wr = 0, n_done = 0, cycles = 0;
  logic [31:0] got_q[$];
  ////////////////////////////////////////////////////////////////////////////
  bmt_bus_if bus ();
  bmt_proc_end i_bmt_proc_end (.clk(clk), .rst_n(rst_n), .bus(bus), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_bytes(req_bytes), .req_code(1'b0),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last));
  bmt_mem_end i_bmt_mem_end (.clk(clk), .rst_n(rst_n), .bus(bus), .cfg_burst_en(cfg_burst_en),
    .cfg_cacheable(cfg_cacheable), .cfg_size(cfg_size), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wr(mem_wr));
  bmt_bus_chk i_bmt_bus_chk (.clk(clk), .rst_n(rst_n), .upper_address_bits(bus.upper_address_bits),
    .address_strobe_n(bus.address_strobe_n), .last_transfer_n(bus.last_transfer_n),
    .mem_io(bus.mem_io), .data_code(bus.data_code), .write_read(bus.write_read),
    .ready_n(bus.ready_n), .burst_ready_n(bus.burst_ready_n),
    .cache_enable_in_n(bus.cache_enable_in_n), .bus_size_byte_n(bus.bus_size_byte_n),
    .bus_size_half_n(bus.bus_size_half_n));
  ////////////////////////////////////////////////////////////////////////////
  // Data tied to the word address so a wrong order shows in the returned data
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  assign mem_rdata = pat(mem_addr);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (!bus.address_strobe_n) n_strobe++;
    if (!bus.last_transfer_n && !(bus.ready_n && bus.burst_ready_n)) n_last++;
    if (mem_wr) n_wr++;
    if (rsp_valid) got_q.push_back(rsp_data);
    if (rsp_valid && rsp_last) n_done++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One whole transfer, then its item, strobe, last and write counts, and the data of 32-bit reads
  task automatic run(input bmt_kind_e k, input logic [31:0] a, input logic [4:0] nb, input logic be,
                     input logic ca, input bmt_size_e sz, input int items);
    int s0, l0, w0, d0, wd, i;
    logic [31:0] ea;
    @(negedge clk);
    cfg_burst_en = be;
    cfg_cacheable = ca;
    cfg_size = sz;
    got_q.delete();
    s0 = n_strobe;
    l0 = n_last;
    w0 = n_wr;
    d0 = n_done;
    wd = 0;
    while (req_ready !== 1'b1 && wd < 50) begin
      @(negedge clk);
      wd++;
    end
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_bytes = nb;
    @(negedge clk);
    req_valid = 1'b0;
    while (n_done == d0 && wd < 300) begin
      @(negedge clk);
      wd++;
    end
    @(negedge clk);
    `CHK("items", items, got_q.size())
    `CHK("strobes", (be && k != BMT_CYC_SPECIAL) ? 1 : items, n_strobe - s0)
    `CHK("last", 1, n_last - l0)
    `CHK("writes", (k == BMT_CYC_MEM_WRITE) ? items : 0, n_wr - w0)
    if (sz == BMT_SZ_32 && k == BMT_CYC_MEM_READ) begin
      for (i = 0; i < items && i < got_q.size(); i++) begin
        ea = {a[31:4], a[3:2] ^ i[1:0], 2'h0};
        `CHK("read data", pat(ea), got_q[i])
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    run(BMT_CYC_MEM_READ, 32'h00000100, 5'h04, 1'b1, 1'b0, BMT_SZ_32, 1);
    run(BMT_CYC_MEM_READ, 32'h00000104, 5'h08, 1'b1, 1'b0, BMT_SZ_32, 2);
    run(BMT_CYC_MEM_READ, 32'h00000108, 5'h08, 1'b0, 1'b0, BMT_SZ_32, 2);
    run(BMT_CYC_MEM_READ, 32'h00000400, 5'h10, 1'b1, 1'b0, BMT_SZ_32, 4);
    run(BMT_CYC_MEM_READ, 32'h000001C4, 5'h04, 1'b1, 1'b1, BMT_SZ_32, 4);
    run(BMT_CYC_MEM_READ, 32'h00000208, 5'h04, 1'b0, 1'b1, BMT_SZ_32, 4);
    run(BMT_CYC_MEM_READ, 32'h0000030C, 5'h10, 1'b1, 1'b0, BMT_SZ_32, 4);
    run(BMT_CYC_SPECIAL, 32'h00000000, 5'h04, 1'b1, 1'b0, BMT_SZ_32, 1);
    run(BMT_CYC_MEM_WRITE, 32'h00000500, 5'h04, 1'b1, 1'b1, BMT_SZ_8, 4);
    run(BMT_CYC_MEM_WRITE, 32'h00000504, 5'h04, 1'b0, 1'b0, BMT_SZ_16, 2);
    run(BMT_CYC_MEM_READ, 32'h00000604, 5'h08, 1'b1, 1'b0, BMT_SZ_16, 4);
    test_done();
  end
endmodule
